// file: pkg/pbcs_cfg.svh
// Register offsets, bit positions, status upper bits and reset window length of the basic control bank
`ifndef PBCS_CFG_SVH
`define PBCS_CFG_SVH
`define PBCS_OFS_CTRL      5'h00
`define PBCS_OFS_STAT      5'h01
`define PBCS_BIT_RESET     15
`define PBCS_BIT_LOOP      14
`define PBCS_BIT_SPEED     13
`define PBCS_BIT_ANEN      12
`define PBCS_BIT_PDOWN     11
`define PBCS_BIT_ISOL      10
`define PBCS_BIT_RESTART   9
`define PBCS_BIT_DUPLEX    8
`define PBCS_BIT_COLTEST   7
`define PBCS_STAT_UPPER    3'h3
`define PBCS_RST_CYCLES    4'h3
`endif

// file: pkg/pbcs_pkg.sv
// Types shared by the basic control and status bank
package pbcs_pkg;
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pbcs_req_t;

  typedef struct packed {
    logic loopback;
    logic speed100;
    logic fullDuplex;
    logic powerDown;
    logic isolate;
    logic colTest;
    logic autonegEn;
  } pbcs_mode_t;
endpackage

// file: hw/pbcs_regs.sv
// Basic control register and upper status bits of the PHY management bank
//
// Function
// - Bit 15 write one resets, self-clears
// - Autoneg enabled ignores forced speed bit
// - Autoneg result overrides speed, duplex; duplex resets one
// - Speed, autoneg reset values from strap
// - Reset from power-down: first clears, second resets
// - Bit 10 one isolates MAC-side interface
// - Bit 9 write one restarts autoneg, self-clears
// - Status 15 reads zero, 14 reads one
// - Status 13 reads one, read-only
`timescale 1ns/100ps
`default_nettype none
`include "pbcs_cfg.svh"

module pbcs_regs
  import pbcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire pbcs_req_t   req,
  output logic      [15:0] rdata,
  output logic             rdValid,
  input  wire logic        strapAutonegSpeed,
  input  wire logic        anegDone,
  input  wire logic        anegSpeed100,
  input  wire logic        anegFullDuplex,
  output pbcs_mode_t       mode,
  output logic             softResetPulse,
  output logic             restartAutonegPulse
);

  // ---------------------------------------------------------------
  // Strap synchroniser
  // ---------------------------------------------------------------
  logic strapMeta_ff;
  logic strapSync_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta_ff <= 1'b0;
      strapSync_ff <= 1'b0;
    end else if (clkEn) begin
      strapMeta_ff <= strapAutonegSpeed;
      strapSync_ff <= strapMeta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire        wrCtrl   = req.wrEn && (req.addr == `PBCS_OFS_CTRL);
  wire        rdCtrl   = req.rdEn && (req.addr == `PBCS_OFS_CTRL);
  wire        rdStat   = req.rdEn && (req.addr == `PBCS_OFS_STAT);
  wire [15:0] wd       = req.wdata;
  wire        wrReset  = wrCtrl && wd[`PBCS_BIT_RESET];

  logic       loop_ff, speed_ff, anen_ff, pdown_ff;
  logic       isol_ff, duplex_ff, col_ff;
  logic [3:0] rstCnt_ff;
  logic       strapLoad_ff;

  // In power-down the reset write only wakes the device up
  wire        fullReset = wrReset && !pdown_ff;
  wire        wakeOnly  = wrReset && pdown_ff;
  wire        inReset   = (rstCnt_ff != 4'h0);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // Strap is relatched a couple of cycles into the reset window so the
  // synchroniser has a settled value after power-on.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstCnt_ff    <= `PBCS_RST_CYCLES;
      strapLoad_ff <= 1'b1;
    end else if (clkEn) begin
      if (fullReset) begin
        rstCnt_ff <= `PBCS_RST_CYCLES;
      end else if (inReset) begin
        rstCnt_ff <= rstCnt_ff - 4'h1;
      end
      strapLoad_ff <= fullReset || (inReset && rstCnt_ff != 4'h1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_ff   <= 1'b0;
      speed_ff  <= 1'b0;
      anen_ff   <= 1'b0;
      pdown_ff  <= 1'b0;
      isol_ff   <= 1'b0;
      duplex_ff <= 1'b1;
      col_ff    <= 1'b0;
    end else if (clkEn) begin
      if (strapLoad_ff || fullReset) begin
        loop_ff   <= 1'b0;
        speed_ff  <= strapSync_ff;
        anen_ff   <= strapSync_ff;
        pdown_ff  <= 1'b0;
        isol_ff   <= 1'b0;
        duplex_ff <= 1'b1;
        col_ff    <= 1'b0;
      end else if (wakeOnly) begin
        pdown_ff  <= 1'b0;
      end else if (wrCtrl) begin
        loop_ff   <= wd[`PBCS_BIT_LOOP];
        speed_ff  <= wd[`PBCS_BIT_SPEED];
        anen_ff   <= wd[`PBCS_BIT_ANEN];
        pdown_ff  <= wd[`PBCS_BIT_PDOWN];
        isol_ff   <= wd[`PBCS_BIT_ISOL];
        duplex_ff <= wd[`PBCS_BIT_DUPLEX];
        col_ff    <= wd[`PBCS_BIT_COLTEST];
      end
    end
  end

  // ---------------------------------------------------------------
  // Strobes and effective mode
  // ---------------------------------------------------------------
  logic swRst_ff, restart_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      swRst_ff   <= 1'b0;
      restart_ff <= 1'b0;
    end else if (clkEn) begin
      swRst_ff   <= fullReset;
      restart_ff <= wrCtrl && !wrReset && wd[`PBCS_BIT_RESTART];
    end
  end
  assign softResetPulse      = swRst_ff;
  assign restartAutonegPulse = restart_ff;

  wire useAneg = anen_ff && anegDone;

  // Under autoneg the negotiated result wins, yet the stored speed and
  // duplex bits still read back as written.
  assign mode = '{
    loopback:   loop_ff,
    speed100:   anen_ff ? anegSpeed100 : speed_ff,
    fullDuplex: anen_ff ? anegFullDuplex : duplex_ff,
    powerDown:  pdown_ff,
    isolate:    isol_ff,
    colTest:    col_ff,
    autonegEn:  anen_ff
  };

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Self-clearing bits are never stored, so they always read zero.
  wire [15:0] ctrlWord = {1'b0, loop_ff, speed_ff, anen_ff, pdown_ff,
                          isol_ff, 1'b0, duplex_ff, col_ff, 7'h00};
  wire [15:0] statWord = {`PBCS_STAT_UPPER, 13'h0000};

  logic [15:0] rdata_ff;
  logic        rdValid_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff   <= 16'h0000;
      rdValid_ff <= 1'b0;
    end else if (clkEn) begin
      rdValid_ff <= req.rdEn;
      rdata_ff   <= rdCtrl ? ctrlWord : (rdStat ? statWord : 16'h0000);
    end
  end
  assign rdata   = rdata_ff;
  assign rdValid = rdValid_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // An ordinary control write that the bank stores as written
  wire plainWr = clkEn && wrCtrl && !wrReset && !strapLoad_ff;

  rst_pulse_a: assert property (
    clkEn && fullReset |=> swRst_ff)
    else $error("soft reset strobe missing");

  rst_selfclr_a: assert property (
    clkEn && rdCtrl |=> !rdata_ff[`PBCS_BIT_RESET])
    else $error("reset bit read back set");

  pulse_once_a: assert property (
    clkEn && swRst_ff && !fullReset |=> !swRst_ff)
    else $error("soft reset strobe too long");

  rst_no_restart_a: assert property (
    clkEn && fullReset |=> !restart_ff)
    else $error("restart strobe on reset write");

  speed_ignored_a: assert property (
    anen_ff |-> mode.speed100 == anegSpeed100)
    else $error("forced speed used under autoneg");

  forced_speed_a: assert property (
    !anen_ff |-> mode.speed100 == speed_ff)
    else $error("forced speed not applied");

  speed_write_a: assert property (
    plainWr |=> speed_ff == $past(wd[`PBCS_BIT_SPEED]))
    else $error("speed bit not stored");

  anen_write_a: assert property (
    plainWr |=> mode.autonegEn == $past(wd[`PBCS_BIT_ANEN]))
    else $error("autoneg enable not stored");

  duplex_override_a: assert property (
    anen_ff |-> mode.fullDuplex == anegFullDuplex)
    else $error("duplex not overridden");

  forced_duplex_a: assert property (
    !anen_ff |-> mode.fullDuplex == duplex_ff)
    else $error("forced duplex not applied");

  duplex_reset_a: assert property (
    clkEn && fullReset |=> duplex_ff)
    else $error("duplex not reset to full");

  strap_load_a: assert property (
    clkEn && fullReset |=> anen_ff == $past(strapSync_ff) &&
    speed_ff == $past(strapSync_ff))
    else $error("strap not relatched");

  pdown_out_a: assert property (
    plainWr && wd[`PBCS_BIT_PDOWN] |=> mode.powerDown)
    else $error("power-down not entered");

  pdown_reset_a: assert property (
    clkEn && fullReset |=> !mode.powerDown)
    else $error("power-down survives reset");

  wake_only_a: assert property (
    clkEn && wakeOnly |=> !pdown_ff && !swRst_ff)
    else $error("first reset write did more than wake");

  wake_keep_a: assert property (
    clkEn && wakeOnly && !strapLoad_ff |=> $stable(isol_ff) &&
    $stable(loop_ff) && $stable(anen_ff))
    else $error("wake write changed other fields");

  isol_out_a: assert property (
    plainWr |=> mode.isolate == $past(wd[`PBCS_BIT_ISOL]))
    else $error("isolate not driven");

  isol_reset_a: assert property (
    clkEn && fullReset |=> !mode.isolate)
    else $error("isolate survives reset");

  restart_a: assert property (
    clkEn && wrCtrl && !wrReset && wd[`PBCS_BIT_RESTART] |=>
    restart_ff ##1 (!restart_ff || !clkEn || $past(wrCtrl)))
    else $error("restart strobe wrong");

  restart_none_a: assert property (
    clkEn && wrCtrl && !wd[`PBCS_BIT_RESTART] |=> !restart_ff)
    else $error("restart strobe without request");

  stat_bits_a: assert property (
    clkEn && rdStat |=> rdata_ff[15:13] == `PBCS_STAT_UPPER)
    else $error("status ability bits wrong");

  low_zero_a: assert property (
    clkEn && rdCtrl |=> rdata_ff[6:0] == 7'h00)
    else $error("reserved bits not zero");

  loop_col_a: assert property (
    plainWr |=> mode.loopback == $past(wd[`PBCS_BIT_LOOP]) &&
    mode.colTest == $past(wd[`PBCS_BIT_COLTEST]))
    else $error("loopback or collision test not stored");

  cov_swreset_c: cover property (fullReset ##1 swRst_ff);
  cov_wake_c:    cover property (wakeOnly ##[1:5] fullReset);
  cov_aneg_c:    cover property (useAneg && mode.speed100);
  cov_restart_c: cover property (restart_ff);
  cov_pdown_c:   cover property (pdown_ff ##1 wakeOnly);

endmodule
`default_nettype wire

// file: test/pbcs_mgr.sv
// Station manager model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module pbcs_mgr
  import pbcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rdValid,
  output pbcs_req_t        req
);
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
    #1;
  endtask
  // A timed-out read hands back unknowns so the caller's compare fails
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    d = 'x;
    @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) req <= '0;
    for (int i = 0; i < 8; i++) begin
      #1;
      if (rdValid === 1'b1) begin
        d = rdata;
        break;
      end
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: test/pbcs_regs_tb_top.sv
// Self-checking bench for the basic control and status bank
`timescale 1ns/100ps
`default_nettype none
`include "pbcs_cfg.svh"
module pbcs_regs_tb_top
  import pbcs_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        strap = 1'b1;
  logic        anegSpeed100 = 1'b0;
  logic        anegFullDuplex = 1'b0;
  logic        rdValid;
  logic        softResetPulse;
  logic        restartAutonegPulse;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [15:0] v;
  logic [15:0] lf = 16'h002a;
  pbcs_req_t   req;
  pbcs_mode_t  mode;
  int          num_errors = 0;
  int          checks_done = 0;
  always #4 clk = ~clk;
  pbcs_regs i_pbcs_regs (.clk(clk), .resetn(resetn), .clkEn(1'b1),
    .req(req), .rdata(rdata), .rdValid(rdValid), .strapAutonegSpeed(strap),
    .anegDone(1'b1), .anegSpeed100(anegSpeed100), .mode(mode),
    .anegFullDuplex(anegFullDuplex), .softResetPulse(softResetPulse),
    .restartAutonegPulse(restartAutonegPulse));
  pbcs_mgr i_pbcs_mgr (.clk(clk), .rdata(rdata), .rdValid(rdValid),
    .req(req));
  function automatic logic [15:0] nxt_lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    i_pbcs_mgr.rd(`PBCS_OFS_STAT, v);
    chk("status", v, 16'h6000);
    i_pbcs_mgr.wr(`PBCS_OFS_STAT, 16'h0000);
    i_pbcs_mgr.rd(`PBCS_OFS_STAT, v);
    chk("status ro", v, 16'h6000);
    i_pbcs_mgr.rd(`PBCS_OFS_CTRL, v);
    chk("ctrl reset", v, 16'h3100);
    i_pbcs_mgr.rd(5'h1f, v);
    chk("unmapped", v, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      lf = nxt_lf(lf);
      d = lf & 16'h77ff;
      @(posedge clk);
      anegSpeed100 <= lf[0];
      anegFullDuplex <= lf[1];
      i_pbcs_mgr.wr(`PBCS_OFS_CTRL, d);
      chk("restart", restartAutonegPulse, d[9]);
      chk("speed", mode.speed100, d[12] ? lf[0] : d[13]);
      chk("duplex", mode.fullDuplex, d[12] ? lf[1] : d[8]);
      chk("loop col", {mode.loopback, mode.colTest}, {d[14], d[7]});
      chk("isolate", mode.isolate, d[10]);
      chk("anen", mode.autonegEn, d[12]);
      i_pbcs_mgr.rd(`PBCS_OFS_CTRL, v);
      chk("ctrl", v, d & 16'h7d80);
    end
    // Strap drops so that the relatch on reset loads zero into speed and autoneg
    @(posedge clk) strap <= 1'b0;
    d = 16'h0c00 | (lf & 16'h4080);
    i_pbcs_mgr.wr(`PBCS_OFS_CTRL, d);
    chk("pdown", mode.powerDown, 1'b1);
    // The first reset write only leaves power-down, the second resets
    i_pbcs_mgr.wr(`PBCS_OFS_CTRL, 16'h8000);
    chk("no reset", softResetPulse, 1'b0);
    i_pbcs_mgr.rd(`PBCS_OFS_CTRL, v);
    chk("pdown cleared", v, d & 16'h77ff);
    i_pbcs_mgr.wr(`PBCS_OFS_CTRL, 16'h8200);
    chk("reset pulse", softResetPulse, 1'b1);
    chk("no restart", restartAutonegPulse, 1'b0);
    repeat (4) @(posedge clk);
    i_pbcs_mgr.rd(`PBCS_OFS_CTRL, v);
    chk("after reset", v, 16'h0100);
    stop_test();
  end
endmodule
`default_nettype wire
